// ===== hte_cfg.svh
// offsets, field positions, reset values and codes of the transmit block
`ifndef HTE_CFG_SVH
`define HTE_CFG_SVH
// ----------------------------------------------------------------
// register offsets (byte port)
// ----------------------------------------------------------------
`define HTE_OFS_CTRL_LOW 8'hC4
`define HTE_OFS_GAP 8'hC5
`define HTE_OFS_EP_COUNT 8'hC6
`define HTE_OFS_EP_RATE 8'hC7
`define HTE_OFS_STATUS 8'hC8
`define HTE_OFS_STATUS_L 8'hC9
`define HTE_OFS_IRQ_EN 8'hCA
`define HTE_OFS_PKT_B0 8'hCC
`define HTE_OFS_PKT_B1 8'hCD
`define HTE_OFS_PKT_B2 8'hCE
`define HTE_OFS_MANUAL 8'hD4
`define HTE_OFS_UPD_REQ 8'hD6
`define HTE_OFS_UPD_STAT 8'hD7
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HTE_BIT_TRIGGER 0
`define HTE_BIT_FILL_ONES 3
`define HTE_BIT_MANUAL_MODE 7
// ----------------------------------------------------------------
// reset values, codes and counts
// ----------------------------------------------------------------
`define HTE_RST_GAP 8'h01
`define HTE_RST_BYTE 8'h00
`define HTE_FLAG 8'h7E
`define HTE_ONES 8'hFF
`define HTE_TOTAL_CONT 8'hFF
`define HTE_CRC_INIT 16'hFFFF
`define HTE_CRC_POLY 16'h8408
`define HTE_EXP_MAX 3'h6
`define HTE_ONES_FILL_MIN 8'h02
`endif

// ===== hte_pkg.sv
// types shared by the transmit framer modules
package hte_pkg;
    typedef enum logic [2:0] {
        HTE_IDLE  = 3'b000,
        HTE_DATA  = 3'b001,
        HTE_FCS1  = 3'b010,
        HTE_FCS2  = 3'b011,
        HTE_CLOSE = 3'b100,
        HTE_GAP   = 3'b101
    } hte_state_type;
endpackage

// ===== hte_err_if.sv
// packet events and error scheduling signals between framer and scheduler
`timescale 1ns/1ps
interface hte_err_if;
    logic pkt_start;
    logic pkt_end;
    logic pkt_auto;
    logic auto_hit;
    logic trig_set;
    logic trig_clr;
    logic [7:0] total;
    logic [6:0] rate;
    logic finished;
    modport core (output pkt_start, pkt_end, pkt_auto, trig_set, trig_clr,
                  total, rate, input auto_hit, finished);
    modport sched (input pkt_start, pkt_end, pkt_auto, trig_set, trig_clr,
                   total, rate, output auto_hit, finished);
endinterface

// ===== hte_crc16.sv
// frame check sequence register, one byte per enable, lsb first
`timescale 1ns/1ps
`include "hte_cfg.svh"
module hte_crc16 (
    input wire logic clk,
    input wire logic nrst,
    input wire logic init,
    input wire logic en,
    input wire logic [7:0] din,
    output logic [15:0] crc_r
);
    // ----------------------------------------------------------------
    // one xor stage per data bit
    // ----------------------------------------------------------------
    logic [15:0] stage [0:8];
    assign stage[0] = crc_r;
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            wire fb = stage[i][0] ^ din[i];
            assign stage[i+1] = (stage[i] >> 1)
                                ^ (fb ? `HTE_CRC_POLY : 16'h0000);
        end
    endgenerate
    // init wins so an opening flag always starts a clean sum
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) crc_r <= `HTE_CRC_INIT;
        else if (init) crc_r <= `HTE_CRC_INIT;
        else if (en) crc_r <= stage[8];
    end
endmodule

// ===== hte_err_sched.sv
// automatic errored packet scheduler: rate interval and run length
`timescale 1ns/1ps
`include "hte_cfg.svh"
module hte_err_sched
    import hte_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    hte_err_if.sched eif
);
    // ----------------------------------------------------------------
    // rate decode: one packet in x * 10^y
    // ----------------------------------------------------------------
    logic active_r;
    logic fin_r;
    logic [23:0] rcnt_r;
    logic [7:0] sent_r;
    logic [19:0] pow;
    wire [3:0] mant = eif.rate[3:0];
    wire [2:0] expo = (eif.rate[6:4] > `HTE_EXP_MAX) ? `HTE_EXP_MAX
                                                     : eif.rate[6:4];
    always_comb begin
        case (expo)
            3'd0: pow = 20'd1;
            3'd1: pow = 20'd10;
            3'd2: pow = 20'd100;
            3'd3: pow = 20'd1000;
            3'd4: pow = 20'd10000;
            3'd5: pow = 20'd100000;
            default: pow = 20'd1000000;
        endcase
    end
    wire [23:0] period = {4'h0, pow} * {20'h00000, mant};
    wire [23:0] rcnt_inc = rcnt_r + 24'd1;
    wire [7:0] sent_inc = sent_r + 8'd1;
    wire rate_on = (mant != 4'h0);
    assign eif.auto_hit = active_r && rate_on && (rcnt_inc >= period);
    assign eif.finished = fin_r;
    wire last_err = eif.pkt_end && eif.pkt_auto && active_r;
    wire run_done = last_err && (eif.total != `HTE_TOTAL_CONT)
                    && (sent_inc == eif.total);
    // ----------------------------------------------------------------
    // run state; a new trigger restarts everything
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            active_r <= 1'b0;
            fin_r <= 1'b0;
            rcnt_r <= 24'h00_0000;
            sent_r <= 8'h00;
        end else if (eif.trig_set) begin
            active_r <= (eif.total != 8'h00);
            fin_r <= (eif.total == 8'h00);
            rcnt_r <= 24'h00_0000;
            sent_r <= 8'h00;
        end else if (eif.trig_clr) begin
            active_r <= 1'b0;
            fin_r <= 1'b0;
        end else begin
            if (eif.pkt_start && active_r)
                rcnt_r <= eif.auto_hit ? 24'h00_0000 : rcnt_inc;
            if (last_err)
                sent_r <= sent_inc;
            if (run_done) begin
                active_r <= 1'b0;
                fin_r <= 1'b1;
            end
        end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    auto_stop_a: assert property (
        run_done && !eif.trig_set && !eif.trig_clr |=> !active_r && fin_r)
        else $error("run did not stop at programmed count");
    continuous_a: assert property (
        active_r && eif.total == `HTE_TOTAL_CONT && !eif.trig_clr
        |=> active_r && !fin_r)
        else $error("continuous insertion stopped");
    rate_zero_a: assert property (
        mant == 4'h0 |-> !eif.auto_hit)
        else $error("insertion with zero mantissa");
    every_pkt_a: assert property (
        active_r && eif.rate == 7'h01 |-> eif.auto_hit)
        else $error("rate 01h did not error every packet");
    exp_clip_a: assert property (
        eif.rate[6:5] == 2'b11 |-> period == 24'd1000000 * mant)
        else $error("exponent above six not clipped");
    interval_a: assert property (
        eif.pkt_start && eif.auto_hit && !eif.trig_set && !eif.trig_clr
        |=> rcnt_r == 24'h00_0000)
        else $error("interval not restarted after errored packet");
endmodule

// ===== hte_tx_core.sv
// transmit hdlc framer with gap control, error insertion and counters
//
// How it works
// - flags plus fill between packets are at least gap value plus one
// - ones fill with gap 2 or 3 gives flag, two ones bytes, flag
// - after trigger, exactly the programmed errored packets, then stop
// - count value all ones inserts errors forever at the rate
// - manual trigger edges insert one error only when mode bit is set
// - manual and automatic insertion run independently together
// - one packet in x times ten to the y is errored
// - zero mantissa disables automatic insertion
// - exponent six or seven both mean one million
// - rate 01h errors every packet; mantissa counts packets directly
// - finished set when run completes or on trigger with count zero, cleared on disable or restart with nonzero count
// - latched finished set on rising edge of live finished
// - interrupt while latched finished and its enable both set
// - 24-bit packet count over three bytes, low byte lowest
// - count every packet taken from the fifo and sent
// - update edge snapshots count, resets live count, sets status
// - latched bit stays until read, sets again only on new event
`timescale 1ns/1ps
`include "hte_cfg.svh"
module hte_tx_core
    import hte_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    input wire logic pkt_valid,
    input wire logic [7:0] pkt_data,
    input wire logic pkt_last,
    output logic pkt_pop,
    input wire logic tx_byte_req,
    output logic [7:0] tx_byte,
    output logic irq
);
    // ----------------------------------------------------------------
    // register bank
    // ----------------------------------------------------------------
    logic fill_ones_r;
    logic [7:0] gap_r;
    logic [7:0] ep_count_r;
    logic [7:0] ep_rate_r;
    logic fin_l_r;
    logic fin_d_r;
    logic irq_en_r;
    logic manual_r;
    logic upd_req_r;
    logic upd_stat_r;
    logic [23:0] live_cnt_r;
    logic [23:0] snap_r;
    // write and read strobes per register
    wire wr_ctrl = cpu_wr && (cpu_addr == `HTE_OFS_CTRL_LOW);
    wire wr_gap = cpu_wr && (cpu_addr == `HTE_OFS_GAP);
    wire wr_cnt = cpu_wr && (cpu_addr == `HTE_OFS_EP_COUNT);
    wire wr_rate = cpu_wr && (cpu_addr == `HTE_OFS_EP_RATE);
    wire wr_ie = cpu_wr && (cpu_addr == `HTE_OFS_IRQ_EN);
    wire wr_man = cpu_wr && (cpu_addr == `HTE_OFS_MANUAL);
    wire wr_upd = cpu_wr && (cpu_addr == `HTE_OFS_UPD_REQ);
    wire rd_latch = cpu_rd && (cpu_addr == `HTE_OFS_STATUS_L);
    wire trig_bit = cpu_wdata[`HTE_BIT_TRIGGER];
    wire manual_mode = ep_rate_r[`HTE_BIT_MANUAL_MODE];

    hte_err_if eif ();
    // trigger write starts a run with current count and rate
    assign eif.trig_set = wr_ctrl && trig_bit;
    // writing the trigger back to zero ends automatic insertion
    assign eif.trig_clr = wr_ctrl && !trig_bit;
    assign eif.total = ep_count_r;
    assign eif.rate = ep_rate_r[6:0];

    hte_err_sched u_sched (
        .clk(clk),
        .nrst(nrst),
        .eif(eif)
    );

    // plain storage registers; trigger bit is write only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fill_ones_r <= 1'b0;
            gap_r <= `HTE_RST_GAP;
            ep_count_r <= `HTE_RST_BYTE;
            ep_rate_r <= `HTE_RST_BYTE;
            irq_en_r <= 1'b0;
            manual_r <= 1'b0;
            upd_req_r <= 1'b0;
        end else begin
            if (wr_ctrl) fill_ones_r <= cpu_wdata[`HTE_BIT_FILL_ONES];
            if (wr_gap) gap_r <= cpu_wdata;
            if (wr_cnt) ep_count_r <= cpu_wdata;
            if (wr_rate) ep_rate_r <= cpu_wdata;
            if (wr_ie) irq_en_r <= cpu_wdata[0];
            if (wr_man) manual_r <= cpu_wdata[0];
            if (wr_upd) upd_req_r <= cpu_wdata[0];
        end
    end

    // ----------------------------------------------------------------
    // finished latch and interrupt
    // ----------------------------------------------------------------
    wire fin_rise = eif.finished && !fin_d_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fin_d_r <= 1'b0;
            fin_l_r <= 1'b0;
            irq <= 1'b0;
        end else begin
            fin_d_r <= eif.finished;
            // set on edge, set wins over the clearing read
            if (fin_rise) fin_l_r <= 1'b1;
            else if (rd_latch) fin_l_r <= 1'b0;
            irq <= fin_l_r && irq_en_r;
        end
    end

    // ----------------------------------------------------------------
    // manual error request, rising edge of the manual register
    // ----------------------------------------------------------------
    logic man_pend_r;
    logic err_pkt_r;
    logic auto_pkt_r;
    logic pkt_start_w;
    // edge counts only with mode bit set
    wire man_edge = wr_man && cpu_wdata[0] && !manual_r && manual_mode;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) man_pend_r <= 1'b0;
        else if (man_edge) man_pend_r <= 1'b1;
        else if (pkt_start_w) man_pend_r <= 1'b0;
    end

    // ----------------------------------------------------------------
    // byte framer
    // ----------------------------------------------------------------
    hte_state_type state_r;
    hte_state_type state_nxt;
    logic [7:0] gap_cnt_r;
    logic [7:0] gap_cnt_nxt;
    logic [7:0] byte_nxt;
    logic crc_init;
    logic crc_en;
    logic pop_nxt;
    logic pkt_end_w;
    logic [15:0] crc_r;
    wire [7:0] fill_byte = fill_ones_r ? `HTE_ONES : `HTE_FLAG;
    // inverted check sequence marks an errored packet
    wire [7:0] err_mask = err_pkt_r ? `HTE_ONES : 8'h00;
    wire [7:0] fcs_lo = ~crc_r[7:0] ^ err_mask;
    wire [7:0] fcs_hi = ~crc_r[15:8] ^ err_mask;
    // two flags already bracket the fill, so gap minus one bytes
    wire [7:0] fill_base = (gap_r > 8'h01) ? (gap_r - 8'h01) : 8'h00;
    // ones fill always carries at least two bytes between flags
    wire [7:0] fill_len = (fill_ones_r && fill_base < `HTE_ONES_FILL_MIN)
                          ? `HTE_ONES_FILL_MIN : fill_base;

    hte_crc16 u_crc (
        .clk(clk),
        .nrst(nrst),
        .init(crc_init),
        .en(crc_en),
        .din(pkt_data),
        .crc_r(crc_r)
    );

    // one byte leaves on each request; the fifo head is assumed whole
    always_comb begin
        state_nxt = state_r;
        gap_cnt_nxt = gap_cnt_r;
        byte_nxt = tx_byte;
        crc_init = 1'b0;
        crc_en = 1'b0;
        pop_nxt = 1'b0;
        pkt_start_w = 1'b0;
        pkt_end_w = 1'b0;
        if (tx_byte_req) begin
            case (state_r)
                HTE_IDLE: begin
                    if (pkt_valid) begin
                        byte_nxt = `HTE_FLAG;
                        crc_init = 1'b1;
                        pkt_start_w = 1'b1;
                        state_nxt = HTE_DATA;
                    end else begin
                        byte_nxt = fill_byte;
                    end
                end
                HTE_DATA: begin
                    if (pkt_valid) begin
                        byte_nxt = pkt_data;
                        crc_en = 1'b1;
                        pop_nxt = 1'b1;
                        if (pkt_last) state_nxt = HTE_FCS1;
                    end else begin
                        // underrun closes the packet early
                        byte_nxt = fcs_lo;
                        state_nxt = HTE_FCS2;
                    end
                end
                HTE_FCS1: begin
                    byte_nxt = fcs_lo;
                    state_nxt = HTE_FCS2;
                end
                HTE_FCS2: begin
                    byte_nxt = fcs_hi;
                    state_nxt = HTE_CLOSE;
                end
                HTE_CLOSE: begin
                    byte_nxt = `HTE_FLAG;
                    pkt_end_w = 1'b1;
                    gap_cnt_nxt = fill_len;
                    state_nxt = (fill_len == 8'h00) ? HTE_IDLE : HTE_GAP;
                end
                HTE_GAP: begin
                    byte_nxt = fill_byte;
                    gap_cnt_nxt = gap_cnt_r - 8'h01;
                    if (gap_cnt_r == 8'h01) state_nxt = HTE_IDLE;
                end
                default: begin
                    byte_nxt = fill_byte;
                    state_nxt = HTE_IDLE;
                end
            endcase
        end
    end
    assign eif.pkt_start = pkt_start_w;
    assign eif.pkt_end = pkt_end_w;
    // only automatic hits count toward the programmed run length
    assign eif.pkt_auto = auto_pkt_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= HTE_IDLE;
            gap_cnt_r <= 8'h00;
            tx_byte <= `HTE_FLAG;
            pkt_pop <= 1'b0;
        end else begin
            state_r <= state_nxt;
            gap_cnt_r <= gap_cnt_nxt;
            tx_byte <= byte_nxt;
            pkt_pop <= pop_nxt;
        end
    end

    // either source marks the packet, neither blocks the other
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            err_pkt_r <= 1'b0;
            auto_pkt_r <= 1'b0;
        end else if (pkt_start_w) begin
            err_pkt_r <= eif.auto_hit || man_pend_r;
            auto_pkt_r <= eif.auto_hit;
        end
    end

    // ----------------------------------------------------------------
    // packet counter with snapshot on update edge
    // ----------------------------------------------------------------
    wire upd_edge = wr_upd && cpu_wdata[0] && !upd_req_r;
    wire [23:0] live_inc = live_cnt_r + 24'd1;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            live_cnt_r <= 24'h00_0000;
            snap_r <= 24'h00_0000;
            upd_stat_r <= 1'b0;
        end else begin
            // a packet ending on the edge cycle starts the new count
            if (upd_edge) begin
                snap_r <= live_cnt_r;
                live_cnt_r <= pkt_end_w ? 24'd1 : 24'h00_0000;
            end else if (pkt_end_w) begin
                live_cnt_r <= live_inc;
            end
            // status rises in the same cycle as the snapshot, drops with request
            if (wr_upd && !cpu_wdata[0]) upd_stat_r <= 1'b0;
            else if (upd_edge) upd_stat_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // read mux, registered; unmapped offsets read zero
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        case (cpu_addr)
            `HTE_OFS_CTRL_LOW: rd_mux = {4'h0, fill_ones_r, 3'b000};
            `HTE_OFS_GAP: rd_mux = gap_r;
            `HTE_OFS_EP_COUNT: rd_mux = ep_count_r;
            `HTE_OFS_EP_RATE: rd_mux = ep_rate_r;
            `HTE_OFS_STATUS: rd_mux = {7'h00, eif.finished};
            `HTE_OFS_STATUS_L: rd_mux = {7'h00, fin_l_r};
            `HTE_OFS_IRQ_EN: rd_mux = {7'h00, irq_en_r};
            `HTE_OFS_PKT_B0: rd_mux = snap_r[7:0];
            `HTE_OFS_PKT_B1: rd_mux = snap_r[15:8];
            `HTE_OFS_PKT_B2: rd_mux = snap_r[23:16];
            `HTE_OFS_MANUAL: rd_mux = {7'h00, manual_r};
            `HTE_OFS_UPD_REQ: rd_mux = {7'h00, upd_req_r};
            `HTE_OFS_UPD_STAT: rd_mux = {7'h00, upd_stat_r};
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) cpu_rdata <= 8'h00;
        else if (cpu_rd) cpu_rdata <= rd_mux;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence close_req_s;
        tx_byte_req && state_r == HTE_CLOSE;
    endsequence
    sequence ones_small_gap_s;
        fill_ones_r && (gap_r == 8'h02 || gap_r == 8'h03);
    endsequence
    gap_min_a: assert property (
        close_req_s |=> tx_byte == `HTE_FLAG
        && ({1'b0, gap_cnt_r} + 9'd2 >= {1'b0, gap_r} + 9'd1))
        else $error("inter-frame gap shorter than setting");
    gap_ones_a: assert property (
        close_req_s and ones_small_gap_s
        |=> state_r == HTE_GAP && gap_cnt_r == 8'h02)
        else $error("ones fill does not give two bytes");
    manual_gate_a: assert property (
        $rose(man_pend_r) |-> $past(wr_man && manual_mode && cpu_wdata[0]))
        else $error("manual error taken with mode off");
    errored_fcs_a: assert property (
        tx_byte_req && state_r == HTE_FCS1 && err_pkt_r
        |=> tx_byte == (~$past(crc_r[7:0]) ^ 8'hFF))
        else $error("errored packet check byte not inverted");
    both_sources_a: assert property (
        pkt_start_w && eif.auto_hit |=> err_pkt_r)
        else $error("automatic error lost under manual mode");
    latch_set_a: assert property (
        $rose(eif.finished) |=> fin_l_r ##1 (fin_l_r || $past(rd_latch)))
        else $error("latched finished not held after edge");
    irq_gate_a: assert property (
        !irq_en_r [*2] |-> !irq)
        else $error("interrupt with enable off");
    snap_a: assert property (
        upd_edge |=> snap_r == $past(live_cnt_r) && upd_stat_r)
        else $error("snapshot or update status wrong");
    pkt_count_a: assert property (
        pkt_end_w && !upd_edge |=> live_cnt_r == $past(live_cnt_r) + 24'd1)
        else $error("packet not counted");
endmodule

// ===== hte_sink.sv
// stream partner: paced byte requests, captured bytes and pop marks
`timescale 1ns/1ps
module hte_sink (
    input wire logic clk,
    input wire logic nrst,
    output logic tx_byte_req,
    input wire logic [7:0] tx_byte,
    input wire logic pkt_pop
);
    logic [7:0] byt_q[$];
    bit pop_q[$];
    bit t1, seen;
    int k;
    initial tx_byte_req = 0;
    // one request in three cycles keeps the spacing the fifo needs;
    // the answer is read a full cycle later, where it stands settled
    always @(negedge clk) begin
        if (t1) begin
            byt_q.push_back(tx_byte);
            pop_q.push_back(seen | pkt_pop);
        end
        t1 = tx_byte_req;
        seen = t1 & pkt_pop;
        k = (k + 1) % 3;
        tx_byte_req <= nrst && k == 0;
    end
endmodule

// ===== hdlc_tx_error_insert_gap_tb.sv
// self-checking bench for the transmit framer and error insertion
`timescale 1ns/1ps
module hdlc_tx_error_insert_gap_tb;
    logic clk = 0, nrst = 0, cpu_wr = 0, cpu_rd = 0, pkt_valid = 0;
    logic [7:0] cpu_addr = 0, cpu_wdata = 0, cpu_rdata, d = 0;
    logic pkt_pop, tx_byte_req, irq;
    logic [7:0] tx_byte;
    logic [15:0] ref_fcs;
    bit have_ref;
    int error_cnt, compares, e, g, tot, left;
    int r[4] = '{8'h03, 8'h11, 8'h70, 8'h71};
    int nn[4] = '{9, 10, 5, 5};
    int ex[4] = '{3, 1, 0, 0};
    always #25 clk = ~clk;
    // fifo model: one constant byte per packet, advanced on each pop
    always @(negedge clk) begin
        if (pkt_pop) left--;
        pkt_valid = left > 0;
    end
    hte_tx_core u_hte_tx_core (.clk(clk), .nrst(nrst), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .pkt_valid(pkt_valid), .pkt_data(d),
        .pkt_last(1'b1), .pkt_pop(pkt_pop), .tx_byte_req(tx_byte_req),
        .tx_byte(tx_byte), .irq(irq));
    hte_sink u_hte_sink (.clk(clk), .nrst(nrst), .tx_byte_req(tx_byte_req),
        .tx_byte(tx_byte), .pkt_pop(pkt_pop));
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk) {cpu_wr, cpu_addr, cpu_wdata} = {1'b1, a, v};
        @(negedge clk) cpu_wr = 0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk) {cpu_rd, cpu_addr} = {1'b1, a};
        @(negedge clk) cpu_rd = 0;
        @(negedge clk) chk({8'h00, cpu_rdata}, {8'h00, v});
    endtask
    // n packets back to back, then framing, gap and check bytes scanned;
    // an inverted check sequence marks an errored packet
    task automatic burst(input int n, input int gp, input bit ones);
        int p, w;
        logic [7:0] b[$];
        bit pq[$];
        u_hte_sink.byt_q.delete();
        u_hte_sink.pop_q.delete();
        left = n;
        tot += n;
        for (w = 0; left > 0 && w < 3000; w++) @(negedge clk);
        if (left > 0) begin
            error_cnt++;
            $display("[FAIL] %0t packet source never drained", $time);
            tally_and_finish;
        end
        repeat (40) @(negedge clk);
        b = u_hte_sink.byt_q;
        pq = u_hte_sink.pop_q;
        e = 0;
        p = -1;
        // the first data byte may sit at index 1, right after its flag
        for (int i = 1; i + 3 < b.size(); i++) if (pq[i]) begin
            if (!have_ref) ref_fcs = {b[i+2], b[i+1]};
            have_ref = 1;
            if ({b[i+2], b[i+1]} === ~ref_fcs) e++;
            else chk({b[i+2], b[i+1]}, ref_fcs);
            chk({b[i-1], b[i+3]}, 16'h7E7E);
            if (p >= 0)
                chk(16'(ones ? i - p == 7 : i - p >= gp + 4), 1);
            if (p >= 0 && ones) chk({b[i-2], b[i-3]}, 16'hFFFF);
            p = i;
        end
    endtask
    initial begin
        void'($urandom(69));
        d = 8'($urandom);
        repeat (12) @(negedge clk);
        nrst = 1;
        rc(8'hC5, 8'h01);
        rc(8'hD0, 8'h00);
        g = $urandom_range(0, 6);
        wr(8'hC5, 8'(g));
        burst(3, g, 0);
        chk(16'(e), 0);
        wr(8'hC4, 8'h08);
        wr(8'hC5, 8'h02);
        burst(3, 2, 1);
        wr(8'hC4, 8'h00);
        // count and rate go in before the trigger
        wr(8'hC6, 8'h03);
        wr(8'hC7, 8'h01);
        wr(8'hC4, 8'h01);
        burst(6, 2, 0);
        chk(16'(e), 3);
        rc(8'hC8, 8'h01);
        chk(16'(irq), 0);
        rc(8'hC9, 8'h01);
        rc(8'hC9, 8'h00);
        wr(8'hCA, 8'h01);
        wr(8'hC4, 8'h00);
        rc(8'hC8, 8'h00);
        wr(8'hC4, 8'h01);
        rc(8'hC8, 8'h00);
        burst(4, 2, 0);
        chk(16'(irq), 1);
        rc(8'hC9, 8'h01);
        chk(16'(irq), 0);
        wr(8'hC6, 8'hFF);
        foreach (r[k]) begin
            wr(8'hC7, 8'(r[k]));
            wr(8'hC4, 8'h01);
            burst(nn[k], 2, 0);
            chk(16'(e), 16'(ex[k]));
            rc(8'hC8, 8'h00);
            wr(8'hC4, 8'h00);
        end
        // cleanup order: both controls zeroed, then the trigger
        wr(8'hC6, 8'h00);
        wr(8'hC7, 8'h00);
        wr(8'hC4, 8'h00);
        wr(8'hD4, 8'h01);
        burst(2, 2, 0);
        chk(16'(e), 0);
        wr(8'hD4, 8'h00);
        wr(8'hC7, 8'h80);
        wr(8'hD4, 8'h01);
        burst(3, 2, 0);
        chk(16'(e), 1);
        wr(8'hD6, 8'h01);
        rc(8'hD7, 8'h01);
        rc(8'hCC, 8'(tot));
        rc(8'hCD, 8'h00);
        wr(8'hD6, 8'h00);
        burst(2, 2, 0);
        wr(8'hD6, 8'h01);
        rc(8'hCC, 8'h02);
        tally_and_finish;
    end
endmodule
